// file: logic/cfgseq_regs.vh
// Constants for the configuration startup sequencer.
// Assumes inclusion by bare name from files under logic/.
`ifndef CFGSEQ_REGS_VH
`define CFGSEQ_REGS_VH

// ----------------------------------------------------------------
// Phase encodings
// ----------------------------------------------------------------
`define CFGSEQ_PH_W          3
`define CFGSEQ_DONE_PH_DEF   3'h4
`define CFGSEQ_TRI_PH_DEF    4'h5
`define CFGSEQ_WE_PH_DEF     4'h6
`define CFGSEQ_PH_LAST       3'h7
// Tristate / write enable selectors: 0..6 phase, DONE, KEEP
`define CFGSEQ_SEL_DONE      4'h8
`define CFGSEQ_SEL_KEEP      4'h9
// Lock / match selectors: 0..6 phase, NO_WAIT_SETTING
`define CFGSEQ_SEL_NO_WAIT_SETTING    4'hF
`define CFGSEQ_LOCK_PH_DEF   4'hF

// ----------------------------------------------------------------
// Option codes
// ----------------------------------------------------------------
`define CFGSEQ_SEC_NONE      2'h0
`define CFGSEQ_SEC_LEVEL1    2'h1
`define CFGSEQ_SEC_LEVEL2    2'h2
`define CFGSEQ_MON_ENABLE    2'h0
`define CFGSEQ_MON_DISABLE   2'h1
`define CFGSEQ_MON_STATUS    2'h2
`define CFGSEQ_PORT_AUTO     2'h0
`define CFGSEQ_PORT_TOP      2'h1
`define CFGSEQ_PORT_BOTTOM   2'h2

// ----------------------------------------------------------------
// Image stream
// ----------------------------------------------------------------
`define CFGSEQ_SYNC_WORD     32'hAA995566
`define CFGSEQ_CRC_POLY      32'h1EDC6F41
`define CFGSEQ_CRC_INIT      32'h00000000
`define CFGSEQ_DBG_ZERO      32'h00000000
`define CFGSEQ_USER_ID_DEF   32'h0FFFFFFF

// ----------------------------------------------------------------
// Timestamp field positions of the user access word
// ----------------------------------------------------------------
`define CFGSEQ_TS_DAY_LSB    27
`define CFGSEQ_TS_MON_LSB    23
`define CFGSEQ_TS_YEAR_LSB   17
`define CFGSEQ_TS_HOUR_LSB   12
`define CFGSEQ_TS_MIN_LSB    6
`define CFGSEQ_TS_SEC_LSB    0

`endif

// file: logic/cfgseq_clk_sense.v
// Samples the configuration clock pin and gives one-cycle rising edge pulses.
// Assumes the pin is asynchronous to sys_clk_i and far slower than it.
`timescale 1ns/1ps
`default_nettype none

module cfgseq_clk_sense (
  input  wire sys_clk_i,
  input  wire rst_i,
  input  wire pin_i,
  output wire rise_o
);

  reg meta_q;
  reg sync_q;
  reg last_q;

  // ----------------------------------------------------------------
  // Two-stage synchroniser, edge seen after the second stage only
  // ----------------------------------------------------------------
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      meta_q <= pin_i;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign rise_o = sync_q & ~last_q;

endmodule
`default_nettype wire

// file: logic/cfgseq_crc.v
// Serial-in-word CRC accumulator for the configuration image.
// Assumes word strobes from the same clock domain.
`timescale 1ns/1ps
`default_nettype none
`include "cfgseq_regs.vh"

module cfgseq_crc #(
  parameter W = 32
) (
  input  wire         sys_clk_i,
  input  wire         rst_i,
  input  wire         clear_i,
  input  wire         step_i,
  input  wire [W-1:0] data_i,
  output wire [W-1:0] crc_o
);

  reg  [W-1:0] crc_q;
  reg  [W-1:0] crc_d;
  reg          fb;
  integer      i;

  // ----------------------------------------------------------------
  // One word folded in per strobe, bit 0 first
  // ----------------------------------------------------------------
  always @* begin
    crc_d = crc_q;
    fb    = 1'b0;
    for (i = 0; i < W; i = i + 1) begin
      fb    = crc_d[W-1] ^ data_i[i];
      crc_d = {crc_d[W-2:0], 1'b0} ^ ({W{fb}} & `CFGSEQ_CRC_POLY);
    end
  end

  always @(posedge sys_clk_i) begin
    if (rst_i || clear_i) begin
      crc_q <= `CFGSEQ_CRC_INIT;
    end else if (step_i) begin
      crc_q <= crc_d;
    end
  end

  assign crc_o = crc_q;

endmodule
`default_nettype wire

// file: logic/cfgseq_top.v
// Configuration image loader and startup sequencer of a programmable device.
// Assumes the source shifts image words MSB first on the configuration clock.
`timescale 1ns/1ps
`default_nettype none
`include "cfgseq_regs.vh"

module cfgseq_top #(
  parameter FRAME_WORDS = 4,
  parameter LOCK_W      = 2
) (
  input  wire              sys_clk_i,
  input  wire              rst_i,
  input  wire              configuration_clock_i,
  input  wire              data_i,
  input  wire              image_start_i,
  input  wire [2:0]        done_phase_i,
  input  wire              done_pipeline_option_i,
  input  wire [3:0]        tristate_release_phase_i,
  input  wire [3:0]        write_enable_phase_i,
  input  wire [3:0]        lock_wait_phase_i,
  input  wire [3:0]        match_wait_phase_i,
  input  wire [LOCK_W-1:0] clock_manager_lock_i,
  input  wire              calib_match_i,
  input  wire              crc_option_i,
  input  wire              per_frame_crc_option_i,
  input  wire              debug_image_option_i,
  input  wire              error_signalling_option_i,
  input  wire              jtag_disable_option_i,
  input  wire              active_reconfig_option_i,
  input  wire [1:0]        security_level_i,
  input  wire [1:0]        monitor_jtag_access_i,
  input  wire [1:0]        config_port_select_i,
  input  wire              overtemp_shutdown_option_i,
  input  wire              over_temp_i,
  input  wire              bram_access_req_i,
  input  wire [31:0]       user_access_word_i,
  input  wire [31:0]       user_revision_id_i,
  output reg               done_o,
  output reg               init_error_n_oe_o,
  output reg               init_error_n_o,
  output reg               config_port_error_out_o,
  output reg               global_tristate_o,
  output reg               global_write_enable_o,
  output reg               bram_access_en_o,
  output reg               global_high_drive_o,
  output reg               global_set_reset_o,
  output reg               boundary_scan_jtag_en_o,
  output reg               readback_en_o,
  output reg               monitor_jtag_en_o,
  output reg               monitor_jtag_status_only_o,
  output reg               config_port_top_o,
  output reg               config_port_bottom_o,
  output reg               shutdown_o,
  output reg [31:0]        user_access_read_port_o,
  output reg [31:0]        user_revision_id_o,
  output reg [31:0]        debug_output_register_o,
  output reg               debug_output_valid_o
);

  localparam ST_IDLE  = 3'h0;
  localparam ST_SYNC  = 3'h1;
  localparam ST_FRAME = 3'h2;
  localparam ST_CRC   = 3'h3;
  localparam ST_START = 3'h4;
  localparam ST_UP    = 3'h5;
  localparam ST_FAIL  = 3'h6;
  localparam integer FW_LAST = FRAME_WORDS - 1;

  // ----------------------------------------------------------------
  // Pin sampling
  // ----------------------------------------------------------------
  wire configuration_clock_rise;
  reg  dat_meta_q;
  reg  dat_q;
  reg  start_meta_q;
  reg  start_q;

  cfgseq_clk_sense u_configuration_clock (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .pin_i     (configuration_clock_i),
    .rise_o    (configuration_clock_rise)
  );

  // Data delayed like the edge detector
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      dat_meta_q   <= 1'b0;
      dat_q        <= 1'b0;
      start_meta_q <= 1'b0;
      start_q      <= 1'b0;
    end else begin
      dat_meta_q   <= data_i;
      dat_q        <= dat_meta_q;
      start_meta_q <= image_start_i;
      start_q      <= start_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // Word assembly
  // ----------------------------------------------------------------
  reg  [31:0] shift_q;
  reg  [4:0]  bit_cnt_q;
  wire [31:0] shift_d = {shift_q[30:0], dat_q};
  wire        word_stb = configuration_clock_rise && (bit_cnt_q == 5'h1F);

  // ----------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------
  reg  [2:0]  state_q;
  reg  [2:0]  phase_q;
  reg  [15:0] word_cnt_q;
  reg  [31:0] frame_addr_q;
  reg         crc_clear_q;
  wire [31:0] crc_val;
  wire        in_frame = (state_q == ST_FRAME);

  // CRC steps only when enabled
  cfgseq_crc #(
    .W (32)
  ) u_crc (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .clear_i   (crc_clear_q),
    .step_i    (word_stb && in_frame && (crc_option_i || per_frame_crc_option_i)),
    .data_i    (shift_d),
    .crc_o     (crc_val)
  );

  wire lock_all = &clock_manager_lock_i;
  wire [3:0] ph4 = {1'b0, phase_q};
  wire lock_hold = (lock_wait_phase_i != `CFGSEQ_SEL_NO_WAIT_SETTING) &&
                   (lock_wait_phase_i == ph4) && !lock_all;
  wire match_hold = (match_wait_phase_i != `CFGSEQ_SEL_NO_WAIT_SETTING) &&
                    (match_wait_phase_i == ph4) && !calib_match_i;
  // Pipelining adds one phase; phase 7 then ends the sequence
  wire [2:0] done_ph = done_phase_i + {2'b00, done_pipeline_option_i};
  wire       per_frame_check = per_frame_crc_option_i || debug_image_option_i;
  wire       last_frame_word = (word_cnt_q == FW_LAST[15:0]);
  wire       crc_bad = (crc_val != shift_d);
  wire       is_done_ph = (phase_q >= done_ph);
  wire       is_err = (state_q == ST_FAIL);

  // ----------------------------------------------------------------
  // Load and startup machine
  // ----------------------------------------------------------------
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_q              <= ST_IDLE;
      phase_q              <= 3'h0;
      bit_cnt_q            <= 5'h00;
      shift_q              <= 32'h00000000;
      word_cnt_q           <= 16'h0000;
      frame_addr_q         <= 32'h00000000;
      crc_clear_q          <= 1'b1;
      debug_output_register_o <= `CFGSEQ_DBG_ZERO;
      debug_output_valid_o <= 1'b0;
    end else begin
      crc_clear_q          <= 1'b0;
      debug_output_valid_o <= 1'b0;
      if (configuration_clock_rise) begin
        shift_q   <= shift_d;
        bit_cnt_q <= bit_cnt_q + 5'h01;
      end
      case (state_q)
        ST_IDLE: begin
          if (start_q) begin
            state_q     <= ST_SYNC;
            crc_clear_q <= 1'b1;
            bit_cnt_q   <= 5'h00;
          end
        end
        ST_SYNC: begin
          // Bit aligned hunt: counter held until the sync word is seen
          bit_cnt_q <= 5'h00;
          if (configuration_clock_rise && shift_d == `CFGSEQ_SYNC_WORD) begin
            state_q    <= ST_FRAME;
            word_cnt_q <= 16'h0000;
            if (debug_image_option_i) begin
              debug_output_register_o <= `CFGSEQ_DBG_ZERO;
              debug_output_valid_o    <= 1'b1;
            end
          end
        end
        ST_FRAME: begin
          if (word_stb) begin
            if (word_cnt_q == 16'h0000) begin
              frame_addr_q <= shift_d;
            end
            word_cnt_q <= word_cnt_q + 16'h0001;
            if (last_frame_word) begin
              state_q    <= ST_CRC;
              word_cnt_q <= 16'h0000;
            end
          end
        end
        ST_CRC: begin
          // Trailer word: this frame's check word; zero ends the image, else a next frame follows
          if (word_stb) begin
            if (per_frame_check && crc_bad) begin
              state_q <= ST_FAIL;
            end else if (shift_d == 32'h00000000) begin
              if (crc_option_i && !per_frame_check && crc_bad) begin
                state_q <= ST_FAIL;
              end else begin
                state_q <= ST_START;
                phase_q <= 3'h0;
              end
            end else begin
              state_q <= ST_FRAME;
            end
            if (per_frame_check) begin
              crc_clear_q <= 1'b1;
            end
            if (debug_image_option_i) begin
              debug_output_register_o <= frame_addr_q;
              debug_output_valid_o    <= 1'b1;
            end
          end
        end
        ST_START: begin
          if (configuration_clock_rise && !lock_hold && !match_hold) begin
            phase_q <= phase_q + 3'h1;
            if (phase_q == `CFGSEQ_PH_LAST - 3'h1) begin
              state_q <= ST_UP;
            end
          end
        end
        ST_UP: begin
          phase_q <= `CFGSEQ_PH_LAST;
        end
        ST_FAIL: begin
          if (start_q) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Startup outputs and option decode
  // ----------------------------------------------------------------
  reg [3:0] tri_sel;
  reg [3:0] we_sel;
  reg       tri_hit;
  reg       we_hit;
  wire      running = (state_q == ST_START) || (state_q == ST_UP);

  always @* begin
    tri_sel = tristate_release_phase_i;
    we_sel  = write_enable_phase_i;
    // Done selection follows done; keep holds the current level
    if (tri_sel == `CFGSEQ_SEL_DONE) begin
      tri_hit = running && is_done_ph;
    end else if (tri_sel == `CFGSEQ_SEL_KEEP) begin
      tri_hit = !global_tristate_o;
    end else begin
      tri_hit = running && (ph4 >= tri_sel);
    end
    if (we_sel == `CFGSEQ_SEL_DONE) begin
      we_hit = running && is_done_ph;
    end else if (we_sel == `CFGSEQ_SEL_KEEP) begin
      we_hit = global_write_enable_o;
    end else begin
      we_hit = running && (ph4 >= we_sel);
    end
  end

  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      done_o                     <= 1'b0;
      init_error_n_oe_o          <= 1'b0;
      init_error_n_o             <= 1'b1;
      config_port_error_out_o    <= 1'b0;
      global_tristate_o          <= 1'b1;
      global_write_enable_o      <= 1'b0;
      bram_access_en_o           <= 1'b0;
      global_high_drive_o        <= 1'b0;
      global_set_reset_o         <= 1'b0;
      boundary_scan_jtag_en_o    <= 1'b1;
      readback_en_o              <= 1'b0;
      monitor_jtag_en_o          <= 1'b0;
      monitor_jtag_status_only_o <= 1'b0;
      config_port_top_o          <= 1'b0;
      config_port_bottom_o       <= 1'b0;
      shutdown_o                 <= 1'b0;
      user_access_read_port_o    <= 32'h00000000;
      user_revision_id_o         <= `CFGSEQ_USER_ID_DEF;
    end else begin
      done_o                  <= running && is_done_ph;
      global_tristate_o       <= !tri_hit;
      global_write_enable_o   <= we_hit;
      bram_access_en_o        <= we_hit && bram_access_req_i;
      config_port_error_out_o <= is_err;
      // Open drain: driven low only on error
      init_error_n_oe_o       <= is_err && error_signalling_option_i;
      init_error_n_o          <= 1'b0;
      global_high_drive_o     <= !running && !active_reconfig_option_i;
      global_set_reset_o      <= !running && !active_reconfig_option_i;
      boundary_scan_jtag_en_o <= !(jtag_disable_option_i && done_o);
      readback_en_o           <= (security_level_i == `CFGSEQ_SEC_NONE);
      monitor_jtag_en_o       <= (monitor_jtag_access_i != `CFGSEQ_MON_DISABLE);
      monitor_jtag_status_only_o <= (monitor_jtag_access_i == `CFGSEQ_MON_STATUS);
      // Automatic selection settles on the top port
      config_port_top_o       <= (config_port_select_i != `CFGSEQ_PORT_BOTTOM);
      config_port_bottom_o    <= (config_port_select_i == `CFGSEQ_PORT_BOTTOM);
      // Shutdown latches; only a reset brings the device back
      if (overtemp_shutdown_option_i && over_temp_i) begin
        shutdown_o <= 1'b1;
      end
      if (state_q == ST_SYNC) begin
        user_access_read_port_o <= user_access_word_i;
        user_revision_id_o      <= user_revision_id_i;
      end
    end
  end

endmodule
`default_nettype wire

// file: tb/cfgseq_top_properties.sv
// Checker for the configuration startup sequencer top.
// Assumes options static during a load.
`timescale 1ns/1ps
`default_nettype none
`include "cfgseq_regs.vh"

module cfgseq_top_properties (
  input wire logic       sys_clk_i,
  input wire logic       rst_i,
  input wire logic       configuration_clock_i,
  input wire logic       error_signalling_option_i,
  input wire logic       active_reconfig_option_i,
  input wire logic       overtemp_shutdown_option_i,
  input wire logic       over_temp_i,
  input wire logic [1:0] security_level_i,
  input wire logic [1:0] monitor_jtag_access_i,
  input wire logic [1:0] config_port_select_i,
  input wire logic       done_o,
  input wire logic       init_error_n_oe_o,
  input wire logic       init_error_n_o,
  input wire logic       config_port_error_out_o,
  input wire logic       global_write_enable_o,
  input wire logic       bram_access_en_o,
  input wire logic       global_high_drive_o,
  input wire logic       global_set_reset_o,
  input wire logic       readback_en_o,
  input wire logic       monitor_jtag_en_o,
  input wire logic       config_port_top_o,
  input wire logic       config_port_bottom_o,
  input wire logic       shutdown_o
);
  // ----
  // Cycles since the link clock rose
  // ----
  logic       configuration_clock_q;
  logic [3:0] since_q;

  always_ff @(posedge sys_clk_i) begin
    configuration_clock_q <= configuration_clock_i;
    if (rst_i) since_q <= 4'hF;
    else if (configuration_clock_i && !configuration_clock_q) since_q <= 4'h0;
    else if (since_q != 4'hF) since_q <= since_q + 4'h1;
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  // ----
  // Properties
  // ----
  // Window under one link period
  AST_DONE_AFTER_CONFIGURATION_CLOCK: assert property ($rose(done_o) |-> since_q >= 4'h1 && since_q <= 4'h7)
    else $error("done rose away from a link clock rise");
  AST_BRAM_GATED: assert property (bram_access_en_o |-> global_write_enable_o)
    else $error("block RAM access before write enable");
  AST_ERR_PIN_LOW: assert property (init_error_n_oe_o |-> !init_error_n_o)
    else $error("error pin driven but not low");
  AST_ERR_SIGNAL: assert property (
    $rose(config_port_error_out_o) && error_signalling_option_i |-> init_error_n_oe_o)
    else $error("port error without pin error");
  AST_ACTIVE_RECONFIG: assert property (active_reconfig_option_i
    && $past(active_reconfig_option_i) |-> !global_high_drive_o && !global_set_reset_o)
    else $error("high drive or set reset under active reconfig");
  AST_READBACK_SECURE: assert property (
    $past(security_level_i) != `CFGSEQ_SEC_NONE |-> !readback_en_o)
    else $error("readback open while secured");
  AST_MON_DISABLE: assert property (
    $past(monitor_jtag_access_i) == `CFGSEQ_MON_DISABLE |-> !monitor_jtag_en_o)
    else $error("monitor path open while disabled");
  AST_PORT_SELECT: assert property (!$past(rst_i) && $past(config_port_select_i) == 2'h2
    |-> config_port_bottom_o && !config_port_top_o)
    else $error("bottom port not selected");
  AST_SHUTDOWN: assert property (
    overtemp_shutdown_option_i && over_temp_i |-> ##[1:3] shutdown_o)
    else $error("no shutdown on over temperature");

  cover property ($rose(done_o));
  cover property ($rose(config_port_error_out_o));
  cover property ($rose(shutdown_o));
endmodule

bind cfgseq_top cfgseq_top_properties i_props (.*);
`default_nettype wire

// file: tb/cfgseq_src_model.sv
// Serial configuration source: shifts an image and clocks the startup.
// Assumes a go pulse per load; the link clock stands still between loads.
`timescale 1ns/1ps
`default_nettype none

module cfgseq_src_model (
  input  wire logic         go_i,
  input  wire logic [511:0] img_i,
  input  wire logic [9:0]   nbits_i,
  input  wire logic         done_i,
  output logic              configuration_clock_o,
  output logic              data_o,
  output logic              busy_o,
  output logic [7:0]        xr_o
);
  int i;
  int tail;

  initial begin
    configuration_clock_o = 1'b0;
    data_o = 1'b0;
    busy_o = 1'b0;
    xr_o = 8'h0;
  end

  task automatic tick(input logic b, input logic [7:0] inc);
    data_o = b;
    #400 configuration_clock_o = 1'b1;
    xr_o = xr_o + inc;
    #400 configuration_clock_o = 1'b0;
  endtask

  always @(posedge go_i) begin
    busy_o = 1'b1;
    xr_o = 8'h0;
    tail = 0;
    #137;
    for (i = 0; i < nbits_i; i++) tick(img_i[nbits_i - 1 - i], 8'h0);
    // Clock past done, bounded
    while (tail < 8 && xr_o < 8'h28) begin
      tick(~data_o, 8'h1);
      if (done_i) tail++;
    end
    data_o = ~data_o;
    busy_o = 1'b0;
  end
endmodule
`default_nettype wire

// file: tb/cfgseq_top_tb.sv
// Testbench for the configuration startup sequencer top.
// Assumes the source model and bound checker.
`timescale 1ns/1ps
`default_nettype none
`include "cfgseq_regs.vh"

module cfgseq_top_tb;
  logic         sys_clk_i = 1'b0;
  logic         rst_i = 1'b1;
  logic         image_start_i = 1'b0;
  logic [2:0]   done_phase_i = 3'h4;
  logic         done_pipeline_option_i = 1'b0;
  logic [3:0]   tristate_release_phase_i = 4'h5;
  logic [3:0]   write_enable_phase_i = 4'h6;
  logic [3:0]   lock_wait_phase_i = 4'hF;
  logic [3:0]   match_wait_phase_i = 4'hF;
  logic [1:0]   clock_manager_lock_i = 2'h0;
  logic         calib_match_i = 1'b0;
  logic         crc_option_i = 1'b0;
  logic         per_frame_crc_option_i = 1'b0;
  logic         debug_image_option_i = 1'b0;
  logic         error_signalling_option_i = 1'b1;
  logic         jtag_disable_option_i = 1'b0;
  logic         active_reconfig_option_i = 1'b0;
  logic [1:0]   security_level_i = 2'h0;
  logic [1:0]   monitor_jtag_access_i = 2'h0;
  logic [1:0]   config_port_select_i = 2'h0;
  logic         overtemp_shutdown_option_i = 1'b0;
  logic         over_temp_i = 1'b0;
  logic         bram_access_req_i = 1'b0;
  logic [31:0]  user_access_word_i = 32'h0;
  logic [31:0]  user_revision_id_i = 32'h0;
  logic         configuration_clock_i;
  logic         data_i;
  logic         done_o;
  logic         init_error_n_oe_o;
  logic         config_port_error_out_o;
  logic         global_tristate_o;
  logic         global_write_enable_o;
  logic         shutdown_o;
  logic [31:0]  user_access_read_port_o;
  logic [31:0]  user_revision_id_o;
  logic [31:0]  debug_output_register_o;
  logic         debug_output_valid_o;
  logic         go = 1'b0;
  logic         busy;
  logic [511:0] img = 512'h0;
  logic [9:0]   nbits = 10'h0;
  logic [7:0]   xr;
  int           seed = 66;
  int           error_cnt = 0;
  int           checks_done = 0;
  int           dp, tp, wp, dn, dz, de, bad;

  cfgseq_top #(.FRAME_WORDS(4), .LOCK_W(2)) i_dut (
    .*, .init_error_n_o(), .bram_access_en_o(), .global_high_drive_o(),
    .global_set_reset_o(), .boundary_scan_jtag_en_o(), .readback_en_o(),
    .monitor_jtag_en_o(), .monitor_jtag_status_only_o(), .config_port_top_o(),
    .config_port_bottom_o()
  );

  cfgseq_src_model i_src (.go_i(go), .img_i(img), .nbits_i(nbits), .done_i(done_o),
    .configuration_clock_o(configuration_clock_i), .data_o(data_i), .busy_o(busy), .xr_o(xr));

  always #50 sys_clk_i = ~sys_clk_i;

  // ----
  // Rise count per startup event
  // ----
  always @(posedge sys_clk_i) begin
    bram_access_req_i <= ~bram_access_req_i;
    if (done_o === 1'b1 && dp < 0) dp = xr;
    if (global_tristate_o === 1'b0 && tp < 0) tp = xr;
    if (global_write_enable_o === 1'b1 && wp < 0) wp = xr;
    if (debug_output_valid_o === 1'b1) dn++;
    if (debug_output_valid_o === 1'b1 && debug_output_register_o !== 32'h0) dz++;
  end

  function automatic int rnd(input int n);
    return $unsigned($random(seed)) % n;
  endfunction

  // One frame, zero trailer closes the image
  function automatic logic [511:0] image(input logic [31:0] a, input logic [31:0] d);
    return {320'h0, `CFGSEQ_SYNC_WORD, a, d, d, d, 32'h0};
  endfunction

  function automatic int sel_ph(input logic [3:0] s, input int d);
    if (s == `CFGSEQ_SEL_DONE) return d;
    if (s == `CFGSEQ_SEL_KEEP) return -1;
    return int'(s);
  endfunction

  function automatic logic [3:0] rnd_sel;
    int r;
    r = rnd(8);
    return (r < 6) ? 4'(r + 1) : ((r == 6) ? `CFGSEQ_SEL_DONE : `CFGSEQ_SEL_KEEP);
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic test_done;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic rst_sys;
    rst_i <= 1'b1;
    repeat (8) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    dp = -1;
    tp = -1;
    wp = -1;
    dn = 0;
    dz = 0;
    @(posedge sys_clk_i);
  endtask

  // A length of zero only clocks the startup on
  task automatic run(input logic [511:0] v, input int n);
    img <= v;
    nbits <= 10'(n);
    image_start_i <= (n > 0);
    repeat (4) @(posedge sys_clk_i);
    image_start_i <= 1'b0;
    go <= 1'b1;
    @(posedge sys_clk_i);
    go <= 1'b0;
    @(posedge sys_clk_i);
    for (int k = 0; k < 4000 && busy; k++) @(posedge sys_clk_i);
  endtask

  initial begin
    #8000000;
    error_cnt++;
    test_done();
  end

  initial begin
    rst_sys();
    chk("revision reset", `CFGSEQ_USER_ID_DEF, user_revision_id_o);
    chk("write enable reset", 32'h0, 32'(global_write_enable_o));
    for (int r = 0; r < 6; r++) begin
      done_phase_i <= 3'(rnd(6) + 1);
      done_pipeline_option_i <= 1'(rnd(2));
      tristate_release_phase_i <= rnd_sel();
      write_enable_phase_i <= rnd_sel();
      clock_manager_lock_i <= 2'(rnd(4));
      error_signalling_option_i <= 1'(rnd(2));
      jtag_disable_option_i <= 1'(rnd(2));
      active_reconfig_option_i <= 1'(rnd(2));
      overtemp_shutdown_option_i <= 1'(rnd(2));
      security_level_i <= 2'(r % 3);
      monitor_jtag_access_i <= 2'(r % 3);
      config_port_select_i <= 2'((r + 1) % 3);
      user_access_word_i <= r ? 32'($random(seed)) : {5'h11, 4'h9, 6'h00, 5'h0D, 6'h2A, 6'h05};
      user_revision_id_i <= 32'($random(seed));
      if (r == 0) begin
        done_phase_i <= 3'h1;
        tristate_release_phase_i <= `CFGSEQ_SEL_DONE;
        write_enable_phase_i <= `CFGSEQ_SEL_KEEP;
      end
      if (r == 1) begin
        done_phase_i <= 3'h6;
        done_pipeline_option_i <= 1'b1;
      end
      rst_sys();
      run(image(32'($random(seed)), 32'($random(seed))), 192);
      de = int'(done_phase_i) + int'(done_pipeline_option_i);
      chk("done phase", de, dp);
      chk("tristate phase", sel_ph(tristate_release_phase_i, de), tp);
      chk("write enable phase", sel_ph(write_enable_phase_i, de), wp);
      chk("user access", user_access_word_i, user_access_read_port_o);
      chk("revision", user_revision_id_i, user_revision_id_o);
      chk("error unchecked", 32'h0, 32'(config_port_error_out_o));
    end
    // ----
    // Image checks: whole, per frame, debug, silent error pin
    // ----
    done_phase_i <= 3'h4;
    done_pipeline_option_i <= 1'b0;
    overtemp_shutdown_option_i <= 1'b0;
    for (int c = 0; c < 5; c++) begin
      bad = (c == 1 || c == 2 || c == 4);
      crc_option_i <= (c < 2);
      per_frame_crc_option_i <= (c == 2 || c == 4);
      debug_image_option_i <= (c == 3);
      error_signalling_option_i <= (c != 4);
      rst_sys();
      run(image(bad ? 32'h40 : 32'h0, bad ? 32'h1234_5678 : 32'h0), 192);
      chk("image error", bad, 32'(config_port_error_out_o));
      chk("error pin drive", bad && c != 4, 32'(init_error_n_oe_o));
      chk("done", !bad, 32'(done_o));
      chk("debug words", (c == 3) ? 2 : 0, dn);
      chk("debug nonzero", 32'h0, dz);
    end
    // ----
    // Lock and calibration holds
    // ----
    per_frame_crc_option_i <= 1'b0;
    error_signalling_option_i <= 1'b1;
    for (int c = 0; c < 2; c++) begin
      lock_wait_phase_i <= c ? `CFGSEQ_SEL_NO_WAIT_SETTING : 4'h2;
      match_wait_phase_i <= c ? 4'h3 : `CFGSEQ_SEL_NO_WAIT_SETTING;
      clock_manager_lock_i <= 2'h1;
      calib_match_i <= 1'b0;
      rst_sys();
      run(image(32'h0, 32'h0), 192);
      chk("done while held", 32'h0, 32'(done_o));
      clock_manager_lock_i <= 2'h3;
      calib_match_i <= 1'b1;
      run(512'h0, 0);
      chk("rises after release", c ? 1 : 2, dp);
    end
    overtemp_shutdown_option_i <= 1'b1;
    over_temp_i <= 1'b1;
    for (int k = 0; k < 20 && shutdown_o !== 1'b1; k++) @(posedge sys_clk_i);
    chk("shutdown", 32'h1, 32'(shutdown_o));
    test_done();
  end
endmodule
`default_nettype wire
